// >>> logic/flash_front_pkg.sv
// Shared constants and types of the serial flash interface front end.
// Assumes a single 125 MHz system clock that oversamples the serial pins.
package flash_front_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  // Least low time of the hardware reset pin, in ns (plain default)
  localparam int RESET_LOW_MIN_NS = 1000;
  localparam int RESET_LOW_CYCLES = (RESET_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int DUMMY_CLKS_DEFAULT = 8;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_ENTER_FOUR_WIRE = 8'h38;
  localparam logic [7:0] OP_EXIT_FOUR_WIRE = 8'hff;
  localparam logic [7:0] OP_WRITE_VOL_CFG = 8'h81;
  localparam logic [7:0] OP_QUAD_OUT_READ3 = 8'h6b;
  localparam logic [7:0] OP_QUAD_OUT_READ4 = 8'h6c;
  localparam logic [7:0] OP_QUAD_IO_READ3 = 8'heb;
  localparam logic [7:0] OP_QUAD_IO_READ4 = 8'hec;
  localparam logic [7:0] OP_DTR_IO_READ3 = 8'hed;
  localparam logic [7:0] OP_DTR_IO_READ4 = 8'hee;
  localparam logic [7:0] OP_QUAD_PROG3 = 8'h32;
  localparam logic [7:0] OP_QUAD_PROG4 = 8'h34;

  // ---------------------------------------------------------------
  // Configuration byte 0
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_QDTR_A = 8'he7;
  localparam logic [7:0] CFG_QDTR_B = 8'hc7;
  localparam int CFG_DQS_EN_BIT = 1;
  localparam logic [5:0] ADDR_BITS3 = 6'd24;
  localparam logic [5:0] ADDR_BITS4 = 6'd32;
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;
  localparam logic [2:0] UNIT_FIRST = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SPI = 2'b00,
    MODE_FOUR_WIRE = 2'b01,
    MODE_QDTR = 2'b11
  } mode_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_ADDR = 3'b011,
    PH_DUMMY = 3'b010,
    PH_DATA_OUT = 3'b110,
    PH_DATA_IN = 3'b111,
    PH_CFG = 3'b101,
    PH_HOLD = 3'b100
  } phase_type;

  // One read byte with its single-error-correction mark
  typedef struct packed {
    logic ecc;
    logic [7:0] data;
  } rd_word_type;

endpackage

// >>> logic/bit_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs change no faster than the clock can observe.
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;

  sync_type st_r;
  sync_type st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '{s1: INIT, s2: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule // bit_sync

// >>> logic/stream_fifo.sv
// Small first-word-fall-through FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are registered flags.
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap freely, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("stream_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } fifo_type;

  localparam fifo_type FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
                                    full: 1'b0, empty: 1'b1};

  fifo_type st_r;
  fifo_type st_nxt;
  logic push;
  logic pop;

  // Pointer and level update
  always_comb begin
    st_nxt = st_r;
    push = in_valid && !st_r.full;
    pop = out_ready && !st_r.empty;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    st_nxt.full = (st_nxt.cnt == (AW+1)'(DEPTH));
    st_nxt.empty = (st_nxt.cnt == '0);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= FIFO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = !st_r.full;
  assign out_valid = !st_r.empty;
  assign out_data = st_r.mem[st_r.rp];

endmodule // stream_fifo

// >>> logic/flash_front.sv
// Serial flash front end: opcode decode, mode switching, quad/DTR data
// shifting, read strobe, ECC indicator and hardware reset pin.
// Assumes the serial pins are asynchronous to clk and at least four times
// slower; the array side feeds read bytes and takes programmed bytes.
module flash_front #(
  parameter int DUMMY_CLKS = flash_front_pkg::DUMMY_CLKS_DEFAULT,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins (io_in[2] is write_guard_io2)
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  // Strobe and open-drain ECC flag
  output logic dqs_out,
  output logic dqs_oe_n,
  output logic ecc_fix_flag_n_out,
  output logic ecc_fix_flag_n_oe_n,
  // Array side: read requests and read bytes
  output logic [31:0] rd_addr,
  output logic rd_start,
  input wire logic rd_word_valid,
  output logic rd_word_ready,
  input wire flash_front_pkg::rd_word_type rd_word,
  // Array side: programmed bytes
  output logic [7:0] wr_data,
  output logic wr_valid,
  // Status
  output flash_front_pkg::mode_type mode_state
);

  if (DUMMY_CLKS < 1 || DUMMY_CLKS > 255) begin : g_bad_dummy
    $error("flash_front dummy clocks must lie in 1..255");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    flash_front_pkg::phase_type phase;
    flash_front_pkg::mode_type mode;
    logic dqs_en;
    logic rst_armed;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic [31:0] addr;
    logic [5:0] abits;
    logic [5:0] atotal;
    logic addr_quad;
    logic xfer_dtr;
    logic is_read;
    logic [7:0] dcnt;
    logic [7:0] out_byte;
    logic nib;
    logic live;
    logic [2:0] unit_idx;
    logic ecc_hold;
    logic [15:0] rst_cnt;
    logic sclk_d;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic dqs_out;
    logic dqs_oe_n;
    logic ecs_level;
    logic ecs_oe_n;
    logic [31:0] rd_addr;
    logic rd_start;
    logic [7:0] wr_data;
    logic wr_valid;
  } front_type;

  localparam front_type FRONT_RST = '{
    phase: flash_front_pkg::PH_IDLE, mode: flash_front_pkg::MODE_SPI,
    dqs_en: 1'b1, io_oe_n: 4'hf, dqs_oe_n: 1'b1, ecs_oe_n: 1'b1,
    default: '0};

  localparam logic [7:0] DUMMY_LAST = 8'(DUMMY_CLKS - 1);
  localparam logic [15:0] RST_LAST = 16'(flash_front_pkg::RESET_LOW_CYCLES);

  front_type st_r;
  front_type st_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] take_in(input logic [7:0] sh,
                                         input logic [3:0] io,
                                         input logic quad);
    return quad ? {sh[3:0], io} : {sh[6:0], io[0]};
  endfunction

  function automatic logic [3:0] step(input logic quad);
    return quad ? 4'd4 : 4'd1;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and read FIFO
  // ---------------------------------------------------------------
  logic sclk_s;
  logic cs_n_s;
  logic rst_pin_s;
  logic [3:0] io_s;

  // Idle levels: clock low, select and reset pin high, lines high
  bit_sync #(.W(7), .INIT(7'h3f)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({sclk, cs_n, reset_pin_n, io_in}),
    .q({sclk_s, cs_n_s, rst_pin_s, io_s})
  );

  logic fifo_valid;
  logic fifo_pop;
  flash_front_pkg::rd_word_type fifo_word;

  stream_fifo #(.WIDTH($bits(flash_front_pkg::rd_word_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(rd_word_valid),
    .in_ready(rd_word_ready),
    .in_data(rd_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  logic rise_w;
  logic fall_w;
  logic dtr_w;
  logic rst_done_w;
  // Edges come from the second sync stage and its delayed copy only
  assign rise_w = sclk_s && !st_r.sclk_d;
  assign fall_w = !sclk_s && st_r.sclk_d;
  assign dtr_w = st_r.xfer_dtr;
  assign rst_done_w = !rst_pin_s && (st_r.rst_cnt == RST_LAST);
  // Pop at the start of each byte; an empty FIFO leaves the byte stale
  assign fifo_pop = !cs_n_s && (st_r.phase == flash_front_pkg::PH_DATA_OUT)
                    && (fall_w || (rise_w && dtr_w)) && !st_r.nib;

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_comb begin
    logic quad;
    logic [7:0] b;
    logic ecc_now;
    quad = 1'b0;
    b = '0;
    ecc_now = 1'b0;
    st_nxt = st_r;
    st_nxt.rd_start = 1'b0;
    st_nxt.wr_valid = 1'b0;
    st_nxt.sclk_d = sclk_s;
    if (cs_n_s) begin
      // Deselect ends any command and floats every output
      st_nxt.phase = flash_front_pkg::PH_IDLE;
      st_nxt.io_oe_n = 4'hf;
      st_nxt.dqs_oe_n = 1'b1;
      st_nxt.ecs_oe_n = 1'b1;
      st_nxt.live = 1'b0;
    end else begin
      // Strobe low from select until data runs, then follows the clock
      st_nxt.dqs_oe_n = !st_r.dqs_en;
      st_nxt.dqs_out = st_r.live ? sclk_s : 1'b0;
      case (st_r.phase)
        flash_front_pkg::PH_IDLE: begin
          st_nxt.phase = flash_front_pkg::PH_CMD;
          st_nxt.bitcnt = '0;
          st_nxt.addr = '0;
          st_nxt.abits = '0;
          st_nxt.xfer_dtr = 1'b0;
        end
        flash_front_pkg::PH_CMD: begin
          // Opcode always on rising edges, four lines outside single mode
          quad = (st_r.mode != flash_front_pkg::MODE_SPI);
          if (rise_w) begin
            b = take_in(st_r.sh, io_s, quad);
            st_nxt.sh = b;
            st_nxt.bitcnt = st_r.bitcnt + step(quad);
            if (st_nxt.bitcnt == flash_front_pkg::BITS_PER_BYTE) begin
              st_nxt.bitcnt = '0;
              st_nxt.phase = flash_front_pkg::PH_HOLD;
              st_nxt.rst_armed = (b == flash_front_pkg::OP_RESET_ENABLE);
              st_nxt.addr_quad = quad;
              st_nxt.xfer_dtr = (st_r.mode == flash_front_pkg::MODE_QDTR);
              st_nxt.atotal = flash_front_pkg::ADDR_BITS3;
              st_nxt.is_read = 1'b1;
              case (b)
                flash_front_pkg::OP_RESET: begin
                  if (st_r.rst_armed) begin
                    st_nxt.mode = flash_front_pkg::MODE_SPI;
                    st_nxt.dqs_en = 1'b1;
                  end
                end
                flash_front_pkg::OP_ENTER_FOUR_WIRE: begin
                  if (st_r.mode == flash_front_pkg::MODE_SPI) begin
                    st_nxt.mode = flash_front_pkg::MODE_FOUR_WIRE;
                  end
                end
                flash_front_pkg::OP_EXIT_FOUR_WIRE: begin
                  if (st_r.mode == flash_front_pkg::MODE_FOUR_WIRE) begin
                    st_nxt.mode = flash_front_pkg::MODE_SPI;
                  end
                end
                flash_front_pkg::OP_WRITE_VOL_CFG: st_nxt.phase = flash_front_pkg::PH_CFG;
                flash_front_pkg::OP_QUAD_OUT_READ3, flash_front_pkg::OP_QUAD_OUT_READ4: begin
                  st_nxt.phase = flash_front_pkg::PH_ADDR;
                end
                flash_front_pkg::OP_QUAD_IO_READ3, flash_front_pkg::OP_QUAD_IO_READ4: begin
                  st_nxt.phase = flash_front_pkg::PH_ADDR;
                  st_nxt.addr_quad = 1'b1;
                end
                flash_front_pkg::OP_DTR_IO_READ3, flash_front_pkg::OP_DTR_IO_READ4: begin
                  st_nxt.phase = flash_front_pkg::PH_ADDR;
                  st_nxt.addr_quad = 1'b1;
                  st_nxt.xfer_dtr = 1'b1;
                end
                flash_front_pkg::OP_QUAD_PROG3, flash_front_pkg::OP_QUAD_PROG4: begin
                  st_nxt.phase = flash_front_pkg::PH_ADDR;
                  st_nxt.is_read = 1'b0;
                end
                default: st_nxt.phase = flash_front_pkg::PH_HOLD;
              endcase
              // The second opcode of each pair carries a four-byte address
              if (b == flash_front_pkg::OP_QUAD_OUT_READ4 || b == flash_front_pkg::OP_QUAD_IO_READ4
                  || b == flash_front_pkg::OP_DTR_IO_READ4
                  || b == flash_front_pkg::OP_QUAD_PROG4) begin
                st_nxt.atotal = flash_front_pkg::ADDR_BITS4;
              end
            end
          end
        end
        flash_front_pkg::PH_ADDR: begin
          if (rise_w || (fall_w && dtr_w)) begin
            quad = st_r.addr_quad;
            st_nxt.addr = quad ? {st_r.addr[27:0], io_s} : {st_r.addr[30:0], io_s[0]};
            st_nxt.abits = st_r.abits + 6'(step(quad));
            if (st_nxt.abits == st_r.atotal) begin
              st_nxt.dcnt = '0;
              st_nxt.bitcnt = '0;
              st_nxt.unit_idx = st_nxt.addr[2:0];
              st_nxt.ecc_hold = 1'b0; // No flag carried over from an earlier read
              if (st_r.is_read) begin
                st_nxt.phase = flash_front_pkg::PH_DUMMY;
                st_nxt.rd_addr = st_nxt.addr;
                st_nxt.rd_start = 1'b1;
              end else begin
                st_nxt.phase = flash_front_pkg::PH_DATA_IN;
              end
            end
          end
        end
        flash_front_pkg::PH_DUMMY: begin
          if (rise_w) begin
            st_nxt.dcnt = st_r.dcnt + 1'b1;
            if (st_r.dcnt == DUMMY_LAST) begin
              st_nxt.phase = flash_front_pkg::PH_DATA_OUT;
              st_nxt.nib = 1'b0;
            end
          end
        end
        flash_front_pkg::PH_DATA_OUT: begin
          // Nibbles change on falling edges, and on rising ones too in DTR
          if (fall_w || (rise_w && dtr_w)) begin
            st_nxt.io_oe_n = 4'h0;
            st_nxt.live = 1'b1;
            st_nxt.nib = !st_r.nib;
            if (!st_r.nib) begin
              if (fifo_valid) begin
                st_nxt.out_byte = fifo_word.data;
                ecc_now = fifo_word.ecc;
              end
              st_nxt.io_out = st_nxt.out_byte[7:4];
              // A unit's flag starts fresh at its first byte
              if (st_r.unit_idx == flash_front_pkg::UNIT_FIRST) begin
                st_nxt.ecc_hold = ecc_now;
              end else begin
                st_nxt.ecc_hold = st_r.ecc_hold || ecc_now;
              end
              st_nxt.unit_idx = st_r.unit_idx + 1'b1;
            end else begin
              st_nxt.io_out = st_r.out_byte[3:0];
            end
          end
          st_nxt.ecs_oe_n = !st_nxt.ecc_hold;
        end
        flash_front_pkg::PH_DATA_IN: begin
          if (rise_w || (fall_w && dtr_w)) begin
            b = take_in(st_r.sh, io_s, 1'b1);
            st_nxt.sh = b;
            st_nxt.bitcnt = st_r.bitcnt + step(1'b1);
            if (st_nxt.bitcnt == flash_front_pkg::BITS_PER_BYTE) begin
              st_nxt.bitcnt = '0;
              st_nxt.wr_data = b;
              st_nxt.wr_valid = 1'b1;
            end
          end
        end
        flash_front_pkg::PH_CFG: begin
          quad = (st_r.mode != flash_front_pkg::MODE_SPI);
          if (rise_w) begin
            b = take_in(st_r.sh, io_s, quad);
            st_nxt.sh = b;
            st_nxt.bitcnt = st_r.bitcnt + step(quad);
            if (st_nxt.bitcnt == flash_front_pkg::BITS_PER_BYTE) begin
              st_nxt.phase = flash_front_pkg::PH_HOLD;
              st_nxt.dqs_en = b[flash_front_pkg::CFG_DQS_EN_BIT];
              if (b == flash_front_pkg::CFG_QDTR_A || b == flash_front_pkg::CFG_QDTR_B) begin
                st_nxt.mode = flash_front_pkg::MODE_QDTR;
              end else if (st_r.mode == flash_front_pkg::MODE_QDTR) begin
                st_nxt.mode = flash_front_pkg::MODE_SPI;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Reset pin overrides everything once held low long enough
    if (rst_pin_s) begin
      st_nxt.rst_cnt = '0;
    end else if (!rst_done_w) begin
      st_nxt.rst_cnt = st_r.rst_cnt + 1'b1;
    end else begin
      st_nxt = FRONT_RST;
      st_nxt.rst_cnt = st_r.rst_cnt;
      st_nxt.sclk_d = sclk_s;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= FRONT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_out = st_r.io_out;
  assign io_oe_n = st_r.io_oe_n;
  assign dqs_out = st_r.dqs_out;
  assign dqs_oe_n = st_r.dqs_oe_n;
  assign ecc_fix_flag_n_out = st_r.ecs_level;
  assign ecc_fix_flag_n_oe_n = st_r.ecs_oe_n;
  assign rd_addr = st_r.rd_addr;
  assign rd_start = st_r.rd_start;
  assign wr_data = st_r.wr_data;
  assign wr_valid = st_r.wr_valid;
  assign mode_state = st_r.mode;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_deselect_idle: assert property (cs_n_s && !rst_done_w |=>
    io_oe_n == 4'hf && st_r.phase == flash_front_pkg::PH_IDLE)
    else $error("outputs not released after deselect");
  a_dqs_low_select: assert property (!cs_n_s && st_r.dqs_en && !st_r.live && !rst_done_w
    |=> !dqs_oe_n && !dqs_out) else $error("strobe not low while selected");
  a_dqs_off_float: assert property (!st_r.dqs_en |=> dqs_oe_n)
    else $error("disabled strobe driven");
  a_dqs_follows_clk: assert property (!cs_n_s && st_r.live && !rst_done_w
    |=> dqs_out == $past(sclk_s)) else $error("strobe not following clock");
  a_qdtr_entry: assert property ($rose(st_r.mode == flash_front_pkg::MODE_QDTR)
    |-> $past(st_r.phase) == flash_front_pkg::PH_CFG) else $error("DTR entered outside cfg");
  a_four_wire_entry: assert property ($rose(st_r.mode == flash_front_pkg::MODE_FOUR_WIRE)
    |-> $past(st_r.phase) == flash_front_pkg::PH_CMD) else $error("four-wire entered badly");
  a_sample_edge: assert property (wr_valid |-> $past(rise_w || (fall_w && dtr_w)))
    else $error("program byte taken off its edge");
  a_out_edge: assert property (!$past(rst_done_w) && $changed(io_out)
    |-> $past(fall_w || (rise_w && dtr_w))) else $error("output changed off its edge");
  a_hw_reset: assert property (rst_done_w ##1 rst_done_w |->
    st_r.mode == flash_front_pkg::MODE_SPI && st_r.dqs_en && io_oe_n == 4'hf)
    else $error("reset pin did not restore defaults");
  a_ecc_in_read: assert property (!ecc_fix_flag_n_oe_n
    |-> st_r.phase == flash_front_pkg::PH_DATA_OUT) else $error("ECC flag outside read");
  a_quad_drive: assert property (io_oe_n != 4'hf
    |-> st_r.phase == flash_front_pkg::PH_DATA_OUT) else $error("IO driven outside read");

endmodule // flash_front

// >>> sim/flash_host.sv
// Host model: a mode 0 or mode 3 serial flash controller driving select, clock and IO.
// Assumes the bench leaves time between frames and checks read data on io_out itself.
module flash_host (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: select high, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'hf;
  end

  // Released lines show the inverse of their last value, not a stale copy
  task automatic sel(input logic lvl);
    cs_n = lvl;
    if (lvl) io = ~io;
    #80;
  endtask

  // Parks the idle clock low (mode 0) or high (mode 3) while deselected
  task automatic park(input logic lvl);
    sclk = lvl;
    #80;
  endtask

  // MSB first; IO2 held high in single mode so the write guard never floats
  // Data changes on the falling edge, the clock returns to its parked level
  task automatic put(input logic [7:0] b, input logic quad);
    logic idle;
    idle = sclk;
    for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
      sclk = 1'b0;
      io = quad ? b[i -: 4] : {3'b111, b[i]};
      #40 sclk = 1'b1;
      #40;
    end
    sclk = idle;
  endtask

  // One or two bytes inside a single select
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic two,
    input logic quad);
    sel(1'b0);
    put(b0, quad);
    if (two) put(b1, quad);
    sel(1'b1);
  endtask
endmodule // flash_host

// >>> sim/serial_flash_interface_modes_bench.sv
// Bench of the flash front end: mode switching, pin reset and strobe enable.
// Assumes the host model in sim/ and the design under logic/.
module serial_flash_interface_modes_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reset_pin_n = 1'b1;
  logic armed = 1'b0;
  logic sclk, cs_n, dqs_out, dqs_oe_n;
  logic fill = 1'b0;
  logic dqs_d = 1'b0;
  logic wr_valid, ecc_oe_n;
  logic [8:0] word = '0;
  logic [7:0] wr_data;
  logic [7:0] data_q[$];
  logic [23:0] adr;
  logic [31:0] rd_addr;
  logic [3:0] io, io_out, io_oe_n;
  logic [31:0] rnd = 32'd27;
  flash_front_pkg::mode_type mode_state, seen_r;
  flash_front_pkg::mode_type exp_q[$];
  int bad_count = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  flash_front #(.DUMMY_CLKS(1)) i_dut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .reset_pin_n(reset_pin_n), .io_in(io), .io_out(io_out), .io_oe_n(io_oe_n),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .ecc_fix_flag_n_out(), .ecc_fix_flag_n_oe_n(ecc_oe_n),
    .rd_addr(rd_addr), .rd_start(), .rd_word_valid(fill), .rd_word_ready(), .rd_word(word),
    .wr_data(wr_data), .wr_valid(wr_valid), .mode_state(mode_state));
  flash_host i_host (.sclk(sclk), .cs_n(cs_n), .io(io));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Settle, then every noted mode change must have shown up
  task automatic done(input string t);
    repeat (20) @(negedge clk);
    check("pending modes", 8'h0, 8'(exp_q.size()));
    check("pending data", 8'h0, 8'(data_q.size()));
    $display("test %s done", t);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watcher: each change of mode takes the oldest note off the queue
  always @(negedge clk) begin
    if (armed && mode_state !== seen_r) begin
      seen_r = mode_state;
      check("mode", exp_q.size() ? {6'h0, exp_q.pop_front()} : 8'hee, {6'h0, mode_state});
    end
    // Host latches read nibbles on rising strobe edges only
    if (dqs_out && !dqs_d && data_q.size() != 0) begin
      check("read nibble", data_q.pop_front(), {4'h0, io_out});
    end
    dqs_d = dqs_out;
    if (wr_valid) begin
      check("program byte", data_q.size() ? data_q.pop_front() : 8'hee, wr_data);
    end
  end

  // Watchdog, far above the some 17 microseconds the tests need
  initial begin
    #200us;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    seen_r = mode_state;
    armed = 1'b1;
    check("mode after reset", 8'h0, {6'h0, mode_state});
    exp_q.push_back(flash_front_pkg::MODE_FOUR_WIRE);
    i_host.frame(8'h38, 8'h00, 1'b0, 1'b0);
    i_host.frame(8'h38, 8'h00, 1'b0, 1'b1);
    done("enter four-wire");
    exp_q.push_back(flash_front_pkg::MODE_SPI);
    i_host.park(1'b1);
    i_host.frame(8'hff, 8'h00, 1'b0, 1'b1);
    i_host.park(1'b0);
    done("exit four-wire");
    exp_q.push_back(flash_front_pkg::MODE_QDTR);
    i_host.frame(8'h81, 8'he7, 1'b1, 1'b0);
    exp_q.push_back(flash_front_pkg::MODE_SPI);
    i_host.frame(8'h66, 8'h00, 1'b0, 1'b1);
    i_host.frame(8'h99, 8'h00, 1'b0, 1'b1);
    done("dtr and soft reset");
    exp_q.push_back(flash_front_pkg::MODE_QDTR);
    i_host.frame(8'h81, 8'hc7, 1'b1, 1'b0);
    exp_q.push_back(flash_front_pkg::MODE_SPI);
    reset_pin_n = 1'b0;
    repeat (200) @(negedge clk);
    reset_pin_n = 1'b1;
    done("reset pin");
    i_host.frame(8'h81, 8'h00, 1'b1, 1'b0);
    i_host.sel(1'b0);
    check("strobe off oe_n", 8'h1, {7'h0, dqs_oe_n});
    i_host.sel(1'b1);
    rnd = xorshift(rnd);
    i_host.frame(8'h81, (rnd[7:0] & 8'h3a) | 8'h02, 1'b1, 1'b0);
    i_host.sel(1'b0);
    check("strobe on oe_n", 8'h0, {7'h0, dqs_oe_n});
    check("strobe level", 8'h0, {7'h0, dqs_out});
    i_host.sel(1'b1);
    done("strobe enable");
    // Quad output read of two bytes from an aligned unit, first byte corrected
    rnd = xorshift(rnd);
    adr = {rnd[23:3], 3'h0};
    data_q.push_back({4'h0, rnd[31:28]});
    data_q.push_back({4'h0, rnd[27:24]});
    i_host.sel(1'b0);
    i_host.put(8'h6b, 1'b0);
    for (int k = 2; k >= 0; k--) begin
      i_host.put(adr[8*k +: 8], 1'b0);
    end
    check("read address", 8'h1, {7'h0, rd_addr === {8'h0, adr}});
    @(negedge clk);
    word = {1'b1, rnd[31:24]};
    fill = 1'b1;
    rnd = xorshift(rnd);
    data_q.push_back({4'h0, rnd[7:4]});
    data_q.push_back({4'h0, rnd[3:0]});
    @(negedge clk);
    word = {1'b0, rnd[7:0]};
    @(negedge clk);
    fill = 1'b0;
    i_host.put(8'h00, 1'b1);
    check("read io oe_n", 8'h0, {4'h0, io_oe_n});
    check("ecc flag oe_n", 8'h0, {7'h0, ecc_oe_n});
    i_host.put(8'h00, 1'b1);
    i_host.put(8'h00, 1'b1);
    i_host.sel(1'b1);
    check("released io oe_n", 8'hf, {4'h0, io_oe_n});
    // Quad program of one byte after a single-line address
    i_host.sel(1'b0);
    i_host.put(8'h32, 1'b0);
    for (int k = 2; k >= 0; k--) begin
      i_host.put(adr[8*k +: 8], 1'b0);
    end
    data_q.push_back(rnd[15:8]);
    i_host.put(rnd[15:8], 1'b1);
    i_host.sel(1'b1);
    done("quad read and program");
    summarize();
  end
endmodule // serial_flash_interface_modes_bench
